// >>> design/sticky_flag_bank.v
`timescale 1ns/1ns
// row of hardware-set flags; a set in the same cycle as a clear wins
module sticky_flag_bank #(
    parameter WIDTH = 4,
    parameter CLEAR_ON_ONE = 0 // 0: writing zero clears, 1: writing one clears
) (
    input wire clk,
    input wire rst,
    input wire syncClear,
    input wire [WIDTH-1:0] setPulse,
    input wire writeEn,
    input wire [WIDTH-1:0] writeData,
    output wire [WIDTH-1:0] flags
);

    reg [WIDTH-1:0] flag_q; // the flags themselves

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gFlag
            // which write value means clear depends on the register style
            wire clearHit = writeEn & (CLEAR_ON_ONE ? writeData[i] : ~writeData[i]);

            // set is tested first so no event is lost during a clear
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    flag_q[i] <= 1'b0;
                end else if (setPulse[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (clearHit || syncClear) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flags = flag_q;

endmodule // sticky_flag_bank

// >>> design/usb_ps2_status_clock_regs.v
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "usb_ps2_status_clock_regs.vh"

// Notes on behaviour
// R01 - endpoint access sets flag, raises enabled interrupt
// R02 - firmware clears flag after servicing endpoint
// R03 - bits 0..2 set on endpoint 0..2
// R04 - bit 3 endpoint 3 flag, next after clear
// R05 - bit 4 selects keyboard bus, resets zero
// R06 - bit 5 selects serial bus, resets zero
// R07 - bit 7 usb marker, power-on reset only
// R08 - clock bit 3 gates engine clock
// R09 - clock bit 4 deep suspend, never in usb
// R10 - clock bit 5 keyboard marker, power-on only
// R11 - clock bit 6 tells engine system frequency
// R12 - clock bit 7 read-only low battery
// R13 - clock bit 1 selects oscillator drive strength
// R14 - table high pointer holds address bits 12..8
// R15 - hardware set beats firmware clear
module usb_ps2_status_clock_regs #(
    parameter ADDR_W = 10
) (
    input wire clk,
    input wire rst,
    input wire softRst,
    // axi4-lite slave
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // interface engine side
    input wire [3:0] epAccess,
    input wire externalEvent,
    input wire usbIntEnable,
    input wire stackFull,
    input wire lowBattery,
    output wire usbIrq,
    output wire ep3Ready,
    output wire selectKeyboardBus,
    output wire selectSerialBus,
    output wire engineClockEnable,
    output wire deepSuspend,
    output wire oscHighDrive,
    output wire sysFreqSixMhz,
    output wire [4:0] tableAddrHigh,
    output wire irq
);

    // write channel holding registers
    reg awHeld_q; // write address taken, not yet used
    reg [ADDR_W-1:0] awAddr_q; // captured write address
    reg wHeld_q; // write data taken, not yet used
    reg [31:0] wData_q; // captured write data
    reg [3:0] wStrb_q; // captured byte enables
    reg bValid_q; // write answer pending
    reg [1:0] bResp_q; // write answer code
    // read channel registers
    reg rValid_q; // read answer pending
    reg [31:0] rData_q; // read data
    reg [1:0] rResp_q; // read answer code

    // register contents
    reg selKbd_q; // keyboard bus select
    reg selSerial_q; // serial bus select
    reg usbMark_q; // firmware usb mode marker
    reg oscDrive_q; // oscillator high drive when set
    reg engClk_q; // interface engine clock on
    reg deepSusp_q; // second suspend mode
    reg kbdMark_q; // firmware keyboard mode marker
    reg sysFreq_q; // one for 6 MHz, zero for 12 MHz
    reg [`TBL_HIGH_W-1:0] tblHigh_q; // table read address bits 12..8
    reg [`IRQ_W-1:0] irqMask_q; // interrupt mask
    reg lowBattPrev_q; // last sampled battery level

    wire [`EP_FLAG_W-1:0] epFlags; // endpoint request flags
    wire [`IRQ_W-1:0] irqStatus; // sticky interrupt status

    // write decode: fires once both halves of the write are held
    wire doWrite = awHeld_q & wHeld_q & ~bValid_q;
    wire [7:0] wrIdx = awAddr_q[9:2];
    wire wrLane = wStrb_q[0]; // all fields sit in byte lane zero
    wire wrEp = doWrite & wrLane & (wrIdx == `IDX_EP_STATUS);
    wire wrClk = doWrite & wrLane & (wrIdx == `IDX_CLK_CTRL);
    wire wrTbl = doWrite & wrLane & (wrIdx == `IDX_TBL_HIGH);
    wire wrIrqSt = doWrite & wrLane & (wrIdx == `IDX_IRQ_STATUS);
    wire wrIrqMk = doWrite & wrLane & (wrIdx == `IDX_IRQ_MASK);
    wire wrHit = (wrIdx == `IDX_EP_STATUS) | (wrIdx == `IDX_CLK_CTRL) |
        (wrIdx == `IDX_TBL_HIGH) | (wrIdx == `IDX_IRQ_STATUS) | (wrIdx == `IDX_IRQ_MASK);

    // handshakes: one outstanding write and one outstanding read
    assign s_axi_awready = ~awHeld_q & ~bValid_q;
    assign s_axi_wready = ~wHeld_q & ~bValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = ~rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

    // write channel: address and data may arrive in either order
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            awHeld_q <= `RST_BIT;
            awAddr_q <= {ADDR_W{1'b0}};
            wHeld_q <= `RST_BIT;
            wData_q <= `RST_WORD;
            wStrb_q <= 4'h0;
            bValid_q <= `RST_BIT;
            bResp_q <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                // unmapped addresses take no effect and answer with an error
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bValid_q <= 1'b1;
                bResp_q <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bValid_q && s_axi_bready) begin
                bValid_q <= 1'b0;
            end
        end
    end

    // read mux, sampled at the edge the address is taken
    reg [7:0] rdByte; // selected register value
    reg rdHit; // address maps to a register
    always @* begin
        rdByte = `RST_BYTE;
        rdHit = 1'b1;
        case (s_axi_araddr[9:2])
            `IDX_EP_STATUS: begin
                // bit 6 is reserved and reads zero
                rdByte = {usbMark_q, 1'b0, selSerial_q, selKbd_q, epFlags};
            end
            `IDX_CLK_CTRL: begin
                // bits 0 and 2 are reserved and read zero
                rdByte = {lowBattery, sysFreq_q, kbdMark_q, deepSusp_q, engClk_q,
                    1'b0, oscDrive_q, 1'b0}; // R12
            end
            `IDX_TBL_HIGH: begin
                rdByte = {3'h0, tblHigh_q}; // R14
            end
            `IDX_IRQ_STATUS: begin
                rdByte = {2'h0, irqStatus};
            end
            `IDX_IRQ_MASK: begin
                rdByte = {2'h0, irqMask_q};
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end

    // read channel: answer on the cycle after the address is taken
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rValid_q <= `RST_BIT;
            rData_q <= `RST_WORD;
            rResp_q <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_q <= 1'b1;
            rData_q <= {24'h00_0000, rdByte};
            rResp_q <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rValid_q && s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

    // endpoint flags: engine sets, firmware writes zero to clear
    // each flag keeps its set until firmware or a soft reset clears it
    sticky_flag_bank #(
        .WIDTH(`EP_FLAG_W),
        .CLEAR_ON_ONE(0)
    ) epBank (
        .clk(clk),
        .rst(rst),
        .syncClear(softRst),
        .setPulse(epAccess), // R01 R03 R15
        .writeEn(wrEp), // R02
        .writeData(wData_q[`EP_FLAG_LSB +: `EP_FLAG_W]),
        .flags(epFlags)
    );

    // endpoint 3 takes no new event until firmware has cleared it
    assign ep3Ready = ~epFlags[`EP_THREE_BIT]; // R04

    // usb interrupt only while enabled and the call stack has room
    assign usbIrq = (|epFlags) & usbIntEnable & ~stackFull; // R01

    // bus selects and markers; markers survive a non power-on reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            selKbd_q <= `RST_BIT;
            selSerial_q <= `RST_BIT;
            usbMark_q <= `RST_BIT;
            kbdMark_q <= `RST_BIT;
        end else begin
            if (softRst) begin
                selKbd_q <= `RST_BIT; // R05
                selSerial_q <= `RST_BIT; // R06
            end else if (wrEp) begin
                selKbd_q <= wData_q[`SEL_KBD_BIT]; // R05
                selSerial_q <= wData_q[`SEL_SERIAL_BIT]; // R06
            end
            // markers ignore the soft reset on purpose
            if (wrEp) begin
                usbMark_q <= wData_q[`USB_MARK_BIT]; // R07
            end
            if (wrClk) begin
                kbdMark_q <= wData_q[`KBD_MARK_BIT]; // R10
            end
        end
    end

    // clock control and table pointer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            oscDrive_q <= `RST_BIT;
            engClk_q <= `RST_BIT;
            deepSusp_q <= `RST_BIT;
            sysFreq_q <= `RST_BIT;
            tblHigh_q <= `RST_TBL_HIGH;
        end else if (softRst) begin
            oscDrive_q <= `RST_BIT;
            engClk_q <= `RST_BIT;
            deepSusp_q <= `RST_BIT;
            sysFreq_q <= `RST_BIT;
            tblHigh_q <= `RST_TBL_HIGH;
        end else begin
            if (wrClk) begin
                oscDrive_q <= wData_q[`OSC_DRIVE_BIT]; // R13
                engClk_q <= wData_q[`ENG_CLK_BIT]; // R08
                sysFreq_q <= wData_q[`SYS_FREQ_BIT]; // R11
                // refused while the serial bus is selected, and cleared on the first edge after the serial bus is selected
                deepSusp_q <= wData_q[`DEEP_SUSP_BIT] & ~selSerial_q; // R09
            end else if (selSerial_q) begin
                deepSusp_q <= 1'b0; // R09
            end
            if (wrTbl) begin
                tblHigh_q <= wData_q[`TBL_HIGH_W-1:0]; // R14
            end
        end
    end

    assign selectKeyboardBus = selKbd_q; // R05
    assign selectSerialBus = selSerial_q; // R06
    assign engineClockEnable = engClk_q; // R08
    assign deepSuspend = deepSusp_q; // R09
    assign oscHighDrive = oscDrive_q; // R13
    assign sysFreqSixMhz = sysFreq_q; // R11
    assign tableAddrHigh = tblHigh_q; // R14

    // battery edge detector; the input is already synchronous
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lowBattPrev_q <= `RST_BIT;
        end else begin
            lowBattPrev_q <= lowBattery;
        end
    end

    // interrupt events: endpoint accesses, external request, battery going low
    wire [`IRQ_W-1:0] irqEvents = {lowBattery & ~lowBattPrev_q, externalEvent, epAccess};

    // sticky status, cleared by writing one
    sticky_flag_bank #(
        .WIDTH(`IRQ_W),
        .CLEAR_ON_ONE(1)
    ) irqBank (
        .clk(clk),
        .rst(rst),
        .syncClear(softRst),
        .setPulse(irqEvents),
        .writeEn(wrIrqSt),
        .writeData(wData_q[`IRQ_W-1:0]),
        .flags(irqStatus)
    );

    // mask register, one enables the matching status bit
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irqMask_q <= `RST_IRQ;
        end else if (softRst) begin
            irqMask_q <= `RST_IRQ;
        end else if (wrIrqMk) begin
            irqMask_q <= wData_q[`IRQ_W-1:0];
        end
    end

    // level interrupt while any unmasked status bit stands
    assign irq = |(irqStatus & irqMask_q);

endmodule // usb_ps2_status_clock_regs

// >>> design/usb_ps2_status_clock_regs.vh
`ifndef USB_PS2_STATUS_CLOCK_REGS_VH
`define USB_PS2_STATUS_CLOCK_REGS_VH

// register indices; the byte address is four times the index
`define IDX_EP_STATUS 8'h1D
`define IDX_CLK_CTRL 8'h1E
`define IDX_TBL_HIGH 8'h1F
`define IDX_IRQ_STATUS 8'h20
`define IDX_IRQ_MASK 8'h21

// endpoint request status fields
`define EP_FLAG_LSB 0
`define EP_FLAG_W 4
`define EP_THREE_BIT 3
`define SEL_KBD_BIT 4
`define SEL_SERIAL_BIT 5
`define USB_MARK_BIT 7

// system clock control fields
`define OSC_DRIVE_BIT 1
`define ENG_CLK_BIT 3
`define DEEP_SUSP_BIT 4
`define KBD_MARK_BIT 5
`define SYS_FREQ_BIT 6
`define LOW_BATT_BIT 7

// table read high pointer field
`define TBL_HIGH_W 5

// interrupt status and mask fields
`define IRQ_W 6
`define IRQ_EXT_BIT 4
`define IRQ_BATT_BIT 5

// reset values
`define RST_BIT 1'h0
`define RST_EP_FLAGS 4'h0
`define RST_TBL_HIGH 5'h00
`define RST_IRQ 6'h00
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> verification/engine_model.sv
`timescale 1ns/1ns
// stand-in for the serial interface engine
module engine_model (
    input wire clk,
    input wire ep3Ready,
    output reg [3:0] epAccess,
    output reg externalEvent,
    output reg lowBattery
);
    // quiet until a test asks for traffic
    initial begin
        epAccess = 4'h0;
        externalEvent = 1'b0;
        lowBattery = 1'b0;
    end
    // battery level from the detector; this model is its only driver
    task batt(input v);
        begin
            lowBattery <= v;
        end
    endtask
    // one-cycle pulse; bits 3:0 endpoints, bit 4 external line
    task hit(input [4:0] m);
        begin
            @(posedge clk);
            // an endpoint 3 hit is dropped until firmware has freed its flag
            epAccess <= {m[3] & ep3Ready, m[2:0]};
            externalEvent <= m[4];
            @(posedge clk);
            epAccess <= 4'h0;
            externalEvent <= 1'b0;
        end
    endtask
endmodule // engine_model

// >>> verification/usb_ps2_status_clock_regs_props.sv
`timescale 1ns/1ns
// pin-level watcher for the register bank
module usb_ps2_status_clock_regs_props (
    input wire clk,
    input wire rst,
    input wire softRst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] epAccess,
    input wire usbIntEnable,
    input wire stackFull,
    input wire usbIrq,
    input wire ep3Ready,
    input wire selectSerialBus,
    input wire deepSuspend,
    input wire engineClockEnable,
    input wire sysFreqSixMhz,
    input wire [4:0] tableAddrHigh
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // an open interrupt path shows a fresh endpoint 0, 1 or 2 hit next cycle
    a_hit_zero_irq: assert property (
        (epAccess[0] && usbIntEnable && !stackFull ##1 usbIntEnable && !stackFull) |-> usbIrq)
        else $error("endpoint 0 hit gave no interrupt");
    a_hit_low_irq: assert property (
        (|epAccess[2:1] && usbIntEnable && !stackFull ##1 usbIntEnable && !stackFull) |-> usbIrq)
        else $error("endpoint 1 or 2 hit gave no interrupt");
    a_full_stack_quiet: assert property (stackFull |-> !usbIrq)
        else $error("interrupt raised with full stack");
    a_ep3_busy: assert property (epAccess[3] |=> !ep3Ready)
        else $error("endpoint 3 still ready after event");
    a_serial_no_deep: assert property (
        selectSerialBus && $past(selectSerialBus) |-> !deepSuspend)
        else $error("deep suspend while serial bus selected");
    // engine clock, frequency and table pointer outputs only move on a register write or a soft reset
    a_ctrl_steady: assert property (
        !$rose(s_axi_bvalid) && !$past(softRst)
        |-> $stable({engineClockEnable, sysFreqSixMhz, tableAddrHigh}))
        else $error("control output moved without a write");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_ep3_event: cover property (epAccess[3]);
    c_usb_irq: cover property (usbIrq);
endmodule // usb_ps2_status_clock_regs_props

bind usb_ps2_status_clock_regs usb_ps2_status_clock_regs_props u_props (.*);

// >>> verification/usb_ps2_status_clock_regs_test.sv
`timescale 1ns/1ns
`include "usb_ps2_status_clock_regs.vh"
// firmware-style register calls against expected values
module usb_ps2_status_clock_regs_test;
    reg clk = 1'b0;
    reg rst = 1'b1; // power-on reset
    reg softRst = 1'b0;
    reg [9:0] awAddr = 10'h000;
    reg [9:0] arAddr = 10'h000;
    reg [31:0] wData = 32'h0000_0000;
    reg [3:0] wStrb = 4'hF; // byte enables, lane zero carries every field
    reg awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    reg usbIntEnable = 1'b1, stackFull = 1'b0;
    wire awReady, wReady, bValid, arReady, rValid, usbIrq, ep3Ready, irq, extEv, lowBat;
    wire selKbd, selSer, clkEn, deepSusp, oscHigh, freqSix;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;
    wire [3:0] epAccess;
    wire [4:0] tblHigh;
    int numErrors = 0, nChecks = 0, cyc = 0;

    always #50 clk = ~clk;

    usb_ps2_status_clock_regs u_usb_ps2_status_clock_regs (
        .clk(clk), .rst(rst), .softRst(softRst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .epAccess(epAccess),
        .externalEvent(extEv), .usbIntEnable(usbIntEnable), .stackFull(stackFull),
        .lowBattery(lowBat), .usbIrq(usbIrq), .ep3Ready(ep3Ready),
        .selectKeyboardBus(selKbd), .selectSerialBus(selSer),
        .engineClockEnable(clkEn), .deepSuspend(deepSusp), .oscHighDrive(oscHigh),
        .sysFreqSixMhz(freqSix), .tableAddrHigh(tblHigh), .irq(irq)
    );
    engine_model u_engine_model (
        .clk(clk), .ep3Ready(ep3Ready), .epAccess(epAccess),
        .externalEvent(extEv), .lowBattery(lowBat)
    );

    // verdict and stop
    task endSim;
        begin
            $display("checks %0d errors %0d", nChecks, numErrors);
            if (numErrors == 0 && nChecks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // compare seen against expected
    task chk(input [31:0] got, input [31:0] exp);
        begin
            nChecks++;
            if (got !== exp) begin
                numErrors++;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one write; response accepted a cycle late to exercise the stall
    task wr(input [7:0] idx, input [7:0] d, input [1:0] er);
        reg a, w;
        begin
            @(posedge clk);
            awAddr <= {idx, 2'b00};
            wData <= {24'h000000, d};
            awValid <= 1'b1;
            wValid <= 1'b1;
            a = 1'b1;
            w = 1'b1;
            while (a || w) begin
                @(posedge clk);
                if (a && awReady) begin
                    a = 1'b0;
                    awValid <= 1'b0;
                end
                if (w && wReady) begin
                    w = 1'b0;
                    wValid <= 1'b0;
                end
            end
            while (bValid !== 1'b1) @(posedge clk);
            bReady <= 1'b1;
            @(posedge clk);
            bReady <= 1'b0;
            chk(bResp, er);
        end
    endtask
    // one read compared with its expected word and answer
    task rd(input [7:0] idx, input [31:0] exp, input [1:0] er);
        begin
            @(posedge clk);
            arAddr <= {idx, 2'b00};
            arValid <= 1'b1;
            do @(posedge clk); while (arReady !== 1'b1);
            arValid <= 1'b0;
            do @(posedge clk); while (rValid !== 1'b1);
            rReady <= 1'b1;
            @(posedge clk);
            rReady <= 1'b0;
            chk(rData, exp);
            chk(rResp, er);
        end
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            numErrors++;
            endSim;
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = `IDX_EP_STATUS; i <= `IDX_IRQ_MASK; i++) begin
            rd(i[7:0], 32'h0, `RESP_OKAY);
        end
        rd(8'h22, 32'h0, `RESP_SLVERR);
        wr(8'h22, 8'hFF, `RESP_SLVERR);
        chk(ep3Ready, 1);
        // masked then unmasked interrupt, then cleared
        u_engine_model.hit(5'h11);
        rd(`IDX_IRQ_STATUS, 32'h11, `RESP_OKAY);
        chk(irq, 0);
        chk(usbIrq, 1);
        wr(`IDX_IRQ_MASK, 8'h3F, `RESP_OKAY);
        chk(irq, 1);
        wr(`IDX_IRQ_STATUS, 8'h11, `RESP_OKAY);
        chk(irq, 0);
        stackFull <= 1'b1;
        rd(`IDX_EP_STATUS, 32'h01, `RESP_OKAY);
        chk(usbIrq, 0);
        stackFull <= 1'b0;
        u_engine_model.hit(5'h06);
        rd(`IDX_EP_STATUS, 32'h07, `RESP_OKAY);
        wr(`IDX_EP_STATUS, 8'hBF, `RESP_OKAY);
        rd(`IDX_EP_STATUS, 32'hB7, `RESP_OKAY);
        wr(`IDX_EP_STATUS, 8'hB0, `RESP_OKAY);
        rd(`IDX_EP_STATUS, 32'hB0, `RESP_OKAY);
        chk({selKbd, selSer}, 2'h3);
        wr(`IDX_CLK_CTRL, 8'h10, `RESP_OKAY);
        rd(`IDX_CLK_CTRL, 32'h00, `RESP_OKAY);
        wr(`IDX_EP_STATUS, 8'h80, `RESP_OKAY);
        wr(`IDX_CLK_CTRL, 8'h7B, `RESP_OKAY);
        rd(`IDX_CLK_CTRL, 32'h7A, `RESP_OKAY);
        chk({oscHigh, clkEn, deepSusp, freqSix}, 4'hF);
        u_engine_model.batt(1'b1);
        wr(`IDX_CLK_CTRL, 8'h20, `RESP_OKAY);
        rd(`IDX_CLK_CTRL, 32'hA0, `RESP_OKAY);
        // battery edge plus the endpoint 1 and 2 hits still sticky
        rd(`IDX_IRQ_STATUS, 32'h26, `RESP_OKAY);
        wr(`IDX_TBL_HIGH, 8'hFF, `RESP_OKAY);
        rd(`IDX_TBL_HIGH, 32'h1F, `RESP_OKAY);
        chk(tblHigh, 5'h1F);
        // a write without byte lane zero leaves the pointer alone
        wStrb <= 4'hE;
        wr(`IDX_TBL_HIGH, 8'h03, `RESP_OKAY);
        wStrb <= 4'hF;
        chk(tblHigh, 5'h1F);
        // engine set lands on the same edge as a firmware clear
        fork
            wr(`IDX_EP_STATUS, 8'h80, `RESP_OKAY);
            begin
                @(posedge clk);
                u_engine_model.hit(5'h01);
            end
        join
        rd(`IDX_EP_STATUS, 32'h81, `RESP_OKAY);
        u_engine_model.hit(5'h08);
        rd(`IDX_EP_STATUS, 32'h89, `RESP_OKAY);
        chk(ep3Ready, 0);
        wr(`IDX_EP_STATUS, 8'h80, `RESP_OKAY);
        chk(ep3Ready, 1);
        softRst <= 1'b1;
        @(posedge clk);
        softRst <= 1'b0;
        rd(`IDX_EP_STATUS, 32'h80, `RESP_OKAY);
        rd(`IDX_CLK_CTRL, 32'hA0, `RESP_OKAY);
        rd(`IDX_TBL_HIGH, 32'h00, `RESP_OKAY);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`IDX_EP_STATUS, 32'h00, `RESP_OKAY);
        rd(`IDX_CLK_CTRL, 32'h80, `RESP_OKAY);
        endSim;
    end
endmodule // usb_ps2_status_clock_regs_test
